//--- pkg/tcl_pkg.sv
package tcl_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH   = 4;  // internal + three external
  localparam int unsigned NUM_BETA = 2;
  localparam int unsigned NUM_IDEAL = 3;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ALARM_MASK  = 8'h1f;
  localparam logic [7:0] ADDR_CONSEC      = 8'h22;
  localparam logic [7:0] ADDR_BETA_CH1    = 8'h25;
  localparam logic [7:0] ADDR_BETA_CH2    = 8'h26;
  localparam logic [7:0] ADDR_IDEAL_CH1   = 8'h27;
  localparam logic [7:0] ADDR_IDEAL_CH2   = 8'h28;
  localparam logic [7:0] ADDR_IDEAL_CH3   = 8'h31;
  localparam logic [7:0] ADDR_HIGH_FLAGS  = 8'h35;
  localparam logic [7:0] ADDR_LOW_FLAGS   = 8'h36;
  localparam logic [7:0] ADDR_OT_FLAGS    = 8'h37;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned AUTO_BETA_BIT   = 3;
  localparam int unsigned BETA_LSB        = 0;
  localparam int unsigned BETA_W          = 3;
  localparam int unsigned IDEAL_W         = 6;
  localparam int unsigned OT_COUNT_LSB    = 4;
  localparam int unsigned ALARM_COUNT_LSB = 1;
  localparam int unsigned COUNT_W         = 3;
  localparam int unsigned TIMEOUT_BIT     = 7;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic            AUTO_BETA_RST   = 1'b1;
  localparam logic [2:0]      BETA_RST        = 3'h0;
  localparam logic [2:0]      BETA_DISABLED   = 3'h7;
  localparam logic [5:0]      IDEAL_RST       = 6'h12;
  localparam logic [3:0]      ALARM_MASK_RST  = 4'h0;
  localparam logic [2:0]      OT_COUNT_RST    = 3'h7;
  localparam logic [2:0]      ALARM_COUNT_RST = 3'h0;
  localparam logic            TIMEOUT_RST     = 1'b0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_CH-1:0] above_high;
    logic [NUM_CH-1:0] below_low;
    logic [NUM_CH-1:0] above_ot;
    logic [NUM_CH-1:0] below_ot_hyst;
  } tcl_cmp_s;

  typedef struct packed {
    logic [NUM_BETA-1:0]       valid;
    logic [NUM_BETA*3-1:0]     value;
  } tcl_beta_det_s;

  // Consecutive-count code to measurement count: 000=1 001=2 011=3 111=4
  function automatic logic [2:0] tcl_consec_need(input logic [2:0] code);
    tcl_consec_need = 3'h1 + {2'h0, code[0]} + {2'h0, code[1]}
                    + {2'h0, code[2]};
  endfunction : tcl_consec_need

endpackage : tcl_pkg

//--- rtl/tcl_sticky_flags.sv
`timescale 1ns/1ps
`default_nettype none
module tcl_sticky_flags
  import tcl_pkg::*;
#(
  parameter int unsigned W = 4
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);

  // Set beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= (q & ~clr) | set; // [R17]
    end
  end

endmodule : tcl_sticky_flags
`default_nettype wire

//--- rtl/tcl_consec_filter.sv
`timescale 1ns/1ps
`default_nettype none
module tcl_consec_filter
  import tcl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       meas_done,
  input  wire logic       exceed,
  input  wire logic [2:0] code,
  output logic            qualified
);

  logic [2:0] run;
  logic [2:0] next_run;

  always_comb begin
    next_run = run;
    if (meas_done) begin
      if (!exceed) begin
        next_run = 3'h0;
      end else if (run != 3'h4) begin
        next_run = run + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      run       <= 3'h0;
      qualified <= 1'b0;
    end else begin
      run       <= next_run;
      qualified <= (next_run >= tcl_consec_need(code)); // [R14]
    end
  end

endmodule : tcl_consec_filter
`default_nettype wire

//--- rtl/tcl_regs.sv
// Overview of operation
// R01: Beta config registers at 25h/26h; bit 3 auto-detect enable, resets one.
// R02: Beta field shows value in use; auto mode ignores host writes.
// R03: Beta codes 000..110 select factors; code 111 disables compensation.
// R04: Six-bit ideality at 27h, 28h, 31h; resets to 010010.
// R05: High flags at 35h set when channel exceeds high limit.
// R06: Reading 35h returns flags then clears them and high summary.
// R07: Low flags at 36h set when channel drops below low limit.
// R08: Reading 36h clears low flags and low summary bit.
// R09: Overtemp flags at 37h set when channel exceeds overtemp limit.
// R10: Any overtemp flag set raises the overtemp summary bit.
// R11: Reading 37h does not clear the overtemp flags.
// R12: Overtemp flag clears once below limit minus hysteresis.
// R13: Overtemp summary clears only when all channel flags clear.
// R14: Pins assert only after the programmed consecutive measurement count; here ext_fault drives the alarm pin without the count.
// R15: Mask bits at 1Fh stop a channel asserting the alarm pin.
// R16: Overtemp pin asserted while any overtemp flag remains set.
// R17: A flag set in the same cycle as its read-clear stays set.
`timescale 1ns/1ps
`default_nettype none
module tcl_regs
  import tcl_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   srst,
  // Register access from the management bus engine
  input  wire logic [7:0]             reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [7:0]             reg_wdata,
  output logic      [7:0]             reg_rdata,
  // Measurement engine
  input  wire logic                   meas_done,
  input  wire tcl_cmp_s               cmp,
  input  wire logic [NUM_CH-1:1]      ext_fault,
  input  wire tcl_beta_det_s          beta_det,
  // Configuration toward the measurement engine
  output logic [NUM_BETA-1:0]         auto_beta_enable,
  output logic [NUM_BETA*3-1:0]       beta_setting,
  output logic [NUM_BETA-1:0]         beta_comp_on,
  output logic [NUM_IDEAL*6-1:0]      ideality_factor,
  output logic                        bus_timeout_enable,
  // Summary bits of the main status register
  output logic                        high_summary,
  output logic                        low_summary,
  output logic                        overtemp_summary,
  // Pins
  output logic                        overtemp_pin,
  output logic                        alarm_pin
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic wr_mask;
  logic wr_consec;
  logic rd_high;
  logic rd_low;
  logic [NUM_BETA-1:0]  wr_beta;
  logic [NUM_IDEAL-1:0] wr_ideal;

  assign wr_mask   = reg_wr && (reg_addr == ADDR_ALARM_MASK);
  assign wr_consec = reg_wr && (reg_addr == ADDR_CONSEC);
  assign wr_beta[0]  = reg_wr && (reg_addr == ADDR_BETA_CH1);
  assign wr_beta[1]  = reg_wr && (reg_addr == ADDR_BETA_CH2);
  assign wr_ideal[0] = reg_wr && (reg_addr == ADDR_IDEAL_CH1);
  assign wr_ideal[1] = reg_wr && (reg_addr == ADDR_IDEAL_CH2);
  assign wr_ideal[2] = reg_wr && (reg_addr == ADDR_IDEAL_CH3);
  assign rd_high   = reg_rd && (reg_addr == ADDR_HIGH_FLAGS);  // [R06]
  assign rd_low    = reg_rd && (reg_addr == ADDR_LOW_FLAGS);   // [R08]

  // ----------------------------------------------------------------
  // Alarm mask and consecutive-count configuration
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] alarm_mask;
  logic [2:0]        overtemp_consecutive_count;
  logic [2:0]        alarm_consecutive_count;

  always_ff @(posedge clk) begin
    if (srst) begin
      alarm_mask <= ALARM_MASK_RST;
    end else if (wr_mask) begin
      alarm_mask <= reg_wdata[NUM_CH-1:0]; // [R15]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      overtemp_consecutive_count <= OT_COUNT_RST;
      alarm_consecutive_count    <= ALARM_COUNT_RST;
      bus_timeout_enable         <= TIMEOUT_RST;
    end else if (wr_consec) begin
      overtemp_consecutive_count <= reg_wdata[OT_COUNT_LSB +: COUNT_W];
      alarm_consecutive_count    <= reg_wdata[ALARM_COUNT_LSB +: COUNT_W];
      bus_timeout_enable         <= reg_wdata[TIMEOUT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Beta compensation configuration
  // ----------------------------------------------------------------
  genvar gb;
  generate
    for (gb = 0; gb < NUM_BETA; gb++) begin : g_beta
      always_ff @(posedge clk) begin
        if (srst) begin
          auto_beta_enable[gb] <= AUTO_BETA_RST; // [R01]
        end else if (wr_beta[gb]) begin
          auto_beta_enable[gb] <= reg_wdata[AUTO_BETA_BIT]; // [R01]
        end
      end

      always_ff @(posedge clk) begin
        if (srst) begin
          beta_setting[gb*3 +: 3] <= BETA_RST;
        end else if (auto_beta_enable[gb]) begin
          if (beta_det.valid[gb]) begin
            beta_setting[gb*3 +: 3] <= beta_det.value[gb*3 +: 3]; // [R02]
          end
        end else if (wr_beta[gb]) begin
          beta_setting[gb*3 +: 3] <= reg_wdata[BETA_LSB +: BETA_W]; // [R02]
        end
      end

      // Compensation follows the field actually stored
      always_ff @(posedge clk) begin
        if (srst) begin
          beta_comp_on[gb] <= (BETA_RST != BETA_DISABLED);
        end else if (auto_beta_enable[gb]) begin
          if (beta_det.valid[gb]) begin
            beta_comp_on[gb] <=
              (beta_det.value[gb*3 +: 3] != BETA_DISABLED); // [R03]
          end
        end else if (wr_beta[gb]) begin
          beta_comp_on[gb] <=
            (reg_wdata[BETA_LSB +: BETA_W] != BETA_DISABLED); // [R03]
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Ideality factors
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IDEAL; gi++) begin : g_ideal
      always_ff @(posedge clk) begin
        if (srst) begin
          ideality_factor[gi*6 +: 6] <= IDEAL_RST; // [R04]
        end else if (wr_ideal[gi]) begin
          ideality_factor[gi*6 +: 6] <= reg_wdata[IDEAL_W-1:0]; // [R04]
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Limit flags
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] high_flags;
  logic [NUM_CH-1:0] low_flags;
  logic [NUM_CH-1:0] ot_flags;
  logic [NUM_CH-1:0] high_set;
  logic [NUM_CH-1:0] low_set;
  logic [NUM_CH-1:0] ot_set;
  logic [NUM_CH-1:0] ot_clr;

  assign high_set = meas_done ? cmp.above_high : '0; // [R05]
  assign low_set  = meas_done ? cmp.below_low  : '0; // [R07]
  assign ot_set   = meas_done ? cmp.above_ot   : '0; // [R09]
  assign ot_clr   = meas_done ? cmp.below_ot_hyst : '0; // [R12]

  tcl_sticky_flags #(.W(NUM_CH)) u_high_flags (
    .clk  (clk),
    .srst (srst),
    .set  (high_set),
    .clr  ({NUM_CH{rd_high}}), // [R06]
    .q    (high_flags)
  );

  tcl_sticky_flags #(.W(NUM_CH)) u_low_flags (
    .clk  (clk),
    .srst (srst),
    .set  (low_set),
    .clr  ({NUM_CH{rd_low}}), // [R08]
    .q    (low_flags)
  );

  // No read term on the clear: reads leave these alone
  tcl_sticky_flags #(.W(NUM_CH)) u_ot_flags (
    .clk  (clk),
    .srst (srst),
    .set  (ot_set),
    .clr  (ot_clr), // [R11] [R12]
    .q    (ot_flags)
  );

  // ----------------------------------------------------------------
  // Summary bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      high_summary     <= 1'b0;
      low_summary      <= 1'b0;
      overtemp_summary <= 1'b0;
    end else begin
      high_summary     <= (high_summary && !rd_high)
                          || (|high_set); // [R06] [R17]
      low_summary      <= (low_summary && !rd_low)
                          || (|low_set); // [R08] [R17]
      overtemp_summary <= |((ot_flags & ~ot_clr) | ot_set); // [R10] [R13]
    end
  end

  // ----------------------------------------------------------------
  // Consecutive qualification and pins
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] ot_qual;
  logic [NUM_CH-1:0] alarm_qual;
  logic [NUM_CH-1:0] alarm_cond;
  logic [NUM_CH-1:0] out_of_limit;

  assign out_of_limit = cmp.above_high | cmp.below_low | cmp.above_ot;
  assign alarm_cond   = (high_flags | low_flags | ot_flags
                        | {ext_fault, 1'b0}) & ~alarm_mask; // [R15]

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_consec
      tcl_consec_filter u_ot_filter (
        .clk       (clk),
        .srst      (srst),
        .meas_done (meas_done),
        .exceed    (cmp.above_ot[gc]),
        .code      (overtemp_consecutive_count),
        .qualified (ot_qual[gc])
      );

      tcl_consec_filter u_alarm_filter (
        .clk       (clk),
        .srst      (srst),
        .meas_done (meas_done),
        .exceed    (out_of_limit[gc]),
        .code      (alarm_consecutive_count),
        .qualified (alarm_qual[gc])
      );
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (srst) begin
      overtemp_pin <= 1'b0;
    end else begin
      overtemp_pin <= (|ot_flags) // [R16]
                      && (overtemp_pin
                          || (|(ot_qual & ot_flags))); // [R14] [R16]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      alarm_pin <= 1'b0;
    end else begin
      alarm_pin <= (|alarm_cond)
                   && (alarm_pin
                       || (|(alarm_cond & (alarm_qual | {ext_fault, 1'b0}))));
      // [R14] [R15]
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      ADDR_ALARM_MASK: next_rdata = {4'h0, alarm_mask};
      ADDR_CONSEC:     next_rdata = {bus_timeout_enable,
                                     overtemp_consecutive_count,
                                     alarm_consecutive_count, 1'b0};
      ADDR_BETA_CH1:   next_rdata = {4'h0, auto_beta_enable[0],
                                     beta_setting[2:0]}; // [R01] [R02]
      ADDR_BETA_CH2:   next_rdata = {4'h0, auto_beta_enable[1],
                                     beta_setting[5:3]}; // [R01] [R02]
      ADDR_IDEAL_CH1:  next_rdata = {2'h0, ideality_factor[5:0]};
      ADDR_IDEAL_CH2:  next_rdata = {2'h0, ideality_factor[11:6]};
      ADDR_IDEAL_CH3:  next_rdata = {2'h0, ideality_factor[17:12]};
      ADDR_HIGH_FLAGS: next_rdata = {4'h0, high_flags}; // [R06]
      ADDR_LOW_FLAGS:  next_rdata = {4'h0, low_flags};
      ADDR_OT_FLAGS:   next_rdata = {4'h0, ot_flags}; // [R09]
      default:         next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule : tcl_regs
`default_nettype wire

//--- test/tcl_meas_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcl_meas_model
  import tcl_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          go,
  input  wire tcl_cmp_s      want,
  input  wire logic [1:0]    det_go,
  input  wire logic [5:0]    det_val,
  output logic               meas_done,
  output tcl_cmp_s           cmp,
  output tcl_beta_det_s      beta_det
);
  // ----------------------------------------------------------
  // Round results, garbage outside the done pulse
  // ----------------------------------------------------------
  always_ff @(posedge clk) begin
    meas_done <= go;
    cmp       <= go ? want : ~cmp;
  end

  always_ff @(posedge clk) begin
    beta_det.valid <= det_go;
    beta_det.value <= |det_go ? det_val : ~beta_det.value;
  end
endmodule : tcl_meas_model
`default_nettype wire

//--- test/tcl_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tcl_regs_sva
  import tcl_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic [7:0]    reg_addr,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic          meas_done,
  input  wire tcl_cmp_s      cmp,
  input  wire tcl_beta_det_s beta_det,
  input  wire logic [1:0]    auto_beta_enable,
  input  wire logic [5:0]    beta_setting,
  input  wire logic          high_summary,
  input  wire logic          low_summary,
  input  wire logic          overtemp_summary,
  input  wire logic          overtemp_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Plain read with no round finishing beside it
  sequence rd_of(logic [7:0] a);
    reg_rd && reg_addr == a && !meas_done;
  endsequence

  sequence round_with(logic [3:0] v);
    meas_done && |v;
  endsequence

  hi_clear_a: assert property (
    rd_of(ADDR_HIGH_FLAGS) |=> !high_summary)
    else $error("high summary kept after read");
  lo_clear_a: assert property (
    rd_of(ADDR_LOW_FLAGS) |=> !low_summary)
    else $error("low summary kept after read");
  hi_set_a: assert property (
    round_with(cmp.above_high) |=> high_summary)
    else $error("high summary not set");
  lo_set_a: assert property (
    round_with(cmp.below_low) |=> low_summary)
    else $error("low summary not set");
  ot_set_a: assert property (
    round_with(cmp.above_ot) |=> overtemp_summary)
    else $error("overtemp summary not set");
  ot_read_keep_a: assert property (
    rd_of(ADDR_OT_FLAGS) and overtemp_summary |=> overtemp_summary)
    else $error("overtemp flags cleared by read");
  ot_fall_cause_a: assert property (
    $fell(overtemp_summary) |-> $past(meas_done))
    else $error("overtemp summary fell without a round");
  pin_follow_a: assert property (
    !overtemp_summary |=> !overtemp_pin)
    else $error("overtemp pin without flags");
  pin_rise_a: assert property (
    $rose(overtemp_pin) |-> $past(overtemp_summary))
    else $error("overtemp pin rose early");
  beta_lock_a: assert property (
    auto_beta_enable[0] && reg_wr && reg_addr == ADDR_BETA_CH1
    && !beta_det.valid[0] |=> $stable(beta_setting[2:0]))
    else $error("beta field written in auto mode");
endmodule : tcl_regs_sva

bind tcl_regs tcl_regs_sva tcl_regs_sva_i (
  .clk, .srst, .reg_addr, .reg_wr, .reg_rd, .meas_done, .cmp,
  .beta_det, .auto_beta_enable, .beta_setting, .high_summary,
  .low_summary, .overtemp_summary, .overtemp_pin
);
`default_nettype wire

//--- test/tcl_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  num_errors++; $display("unexpected %s exp %0h got %0h", n, e, g); \
  end end
module tcl_regs_bench
  import tcl_pkg::*;
;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } tcl_row_s;

  localparam tcl_row_s ROWS [18] = '{
    '{0, 8'h25, 8'h08}, '{0, 8'h26, 8'h08}, '{0, 8'h27, 8'h12},
    '{0, 8'h28, 8'h12}, '{0, 8'h31, 8'h12}, '{0, 8'h35, 8'h00},
    '{0, 8'h36, 8'h00}, '{0, 8'h37, 8'h00}, '{1, 8'h25, 8'hf7},
    '{0, 8'h25, 8'h00}, '{1, 8'h27, 8'hff}, '{0, 8'h27, 8'h3f},
    '{1, 8'h31, 8'h2a}, '{0, 8'h31, 8'h2a}, '{0, 8'h50, 8'h00},
    '{1, 8'h37, 8'hff}, '{0, 8'h37, 8'h00}, '{0, 8'h22, 8'h70}};

  logic          clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, go = 0;
  logic [7:0]    reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic [1:0]    det_go = 0, auto_beta_enable, beta_comp_on;
  logic [5:0]    det_val = 0, beta_setting;
  logic [3:1]    ext_fault = 0;
  logic [17:0]   ideality_factor;
  logic          meas_done, bus_timeout_enable, high_summary;
  logic          low_summary, overtemp_summary, overtemp_pin, alarm_pin;
  tcl_cmp_s      want = '0, cmp;
  tcl_beta_det_s beta_det;
  int            num_errors = 0, cmp_count = 0, cyc = 0;

  tcl_meas_model tcl_meas_model_i (.clk, .go, .want, .det_go,
    .det_val, .meas_done, .cmp, .beta_det);
  tcl_regs tcl_regs_i (.clk, .srst, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .meas_done, .cmp, .ext_fault, .beta_det,
    .auto_beta_enable, .beta_setting, .beta_comp_on, .ideality_factor,
    .bus_timeout_enable, .high_summary, .low_summary,
    .overtemp_summary, .overtemp_pin, .alarm_pin);

  initial forever #5 clk = ~clk;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input string n);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    tick(1);
    `CHK(n, e, reg_rdata)
  endtask : rd

  task automatic meas(input tcl_cmp_s c);
    go <= 1'b1;
    want <= c;
    tick(1);
    go <= 1'b0;
    tick(3);
  endtask : meas

  task automatic results;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      results();
    end
  end

  // ----------------------------------------------------------
  // Register table, then hand-written cases
  // ----------------------------------------------------------
  initial begin
    tick(10);
    srst <= 1'b0;
    tick(1);
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) wr(ROWS[i].addr, ROWS[i].data);
      else rd(ROWS[i].addr, ROWS[i].data, "row");
    end
    `CHK("ideal", {6'h2a, 6'h12, 6'h3f}, ideality_factor)
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_BETA_CH1, 8'(c));
      rd(ADDR_BETA_CH1, 8'(c), "beta");
      `CHK("comp", c != 7, beta_comp_on[0])
    end
    `CHK("auto", 2'h2, auto_beta_enable)
    det_go <= 2'h2;
    det_val <= 6'h38;
    tick(1);
    det_go <= 2'h0;
    tick(3);
    rd(ADDR_BETA_CH2, 8'h0f, "beta2");
    `CHK("comp2", 1'b0, beta_comp_on[1])
    meas(16'ha000);
    `CHK("hsum", 1'b1, high_summary)
    rd(ADDR_HIGH_FLAGS, 8'h0a, "high");
    `CHK("hsum", 1'b0, high_summary)
    rd(ADDR_HIGH_FLAGS, 8'h00, "high");
    meas(16'h0500);
    go <= 1'b1;
    want <= 16'h0100;
    tick(1);
    go <= 1'b0;
    reg_addr <= ADDR_LOW_FLAGS;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    tick(2);
    `CHK("low", 8'h05, reg_rdata)
    `CHK("lsum", 1'b1, low_summary)
    rd(ADDR_LOW_FLAGS, 8'h01, "low");
    `CHK("lsum", 1'b0, low_summary)
    wr(ADDR_CONSEC, 8'h80);
    `CHK("tmout", 1'b1, bus_timeout_enable)
    wr(ADDR_CONSEC, 8'h00);
    meas(16'h0060);
    rd(ADDR_OT_FLAGS, 8'h06, "ot");
    rd(ADDR_OT_FLAGS, 8'h06, "ot");
    `CHK("osum", 1'b1, overtemp_summary)
    `CHK("opin", 1'b1, overtemp_pin)
    meas(16'h0002);
    rd(ADDR_OT_FLAGS, 8'h04, "ot");
    `CHK("osum", 1'b1, overtemp_summary)
    meas(16'h0004);
    `CHK("osum", 1'b0, overtemp_summary)
    `CHK("opin", 1'b0, overtemp_pin)
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CONSEC, 8'((2 ** i - 1) << 4));
      for (int n = 0; n <= i; n++) begin
        `CHK("opin", 1'b0, overtemp_pin)
        meas(16'h0010);
      end
      `CHK("opin", 1'b1, overtemp_pin)
      meas(16'h000f);
      `CHK("opin", 1'b0, overtemp_pin)
    end
    wr(ADDR_CONSEC, 8'h00);
    wr(ADDR_ALARM_MASK, 8'h02);
    meas(16'h2000);
    `CHK("alarm", 1'b0, alarm_pin)
    wr(ADDR_ALARM_MASK, 8'h00);
    meas(16'h2000);
    `CHK("alarm", 1'b1, alarm_pin)
    rd(ADDR_HIGH_FLAGS, 8'h02, "high");
    tick(1);
    `CHK("alarm", 1'b0, alarm_pin)
    ext_fault <= 3'h4;
    tick(2);
    `CHK("alarm", 1'b1, alarm_pin)
    wr(ADDR_ALARM_MASK, 8'h08);
    tick(1);
    `CHK("alarm", 1'b0, alarm_pin)
    ext_fault <= 3'h0;
    wr(ADDR_ALARM_MASK, 8'h00);
    meas(16'h8000);
    srst <= 1'b1;
    tick(2);
    srst <= 1'b0;
    tick(1);
    `CHK("hsum", 1'b0, high_summary)
    `CHK("alarm", 1'b0, alarm_pin)
    `CHK("auto", 2'h3, auto_beta_enable)
    `CHK("ideal", {3{6'h12}}, ideality_factor)
    rd(ADDR_HIGH_FLAGS, 8'h00, "high");
    results();
  end
endmodule : tcl_regs_bench
`default_nettype wire
